// ==== sim/csr_host_model.sv ====
// Purpose: Host side of the status line: strobes and counts reply pulses
// Assumes: Line level resolved by the bench with a pull-up
// Notes:   Optional poke pulls the line low once inside a reply gap
`default_nettype none
module csr_host_model #(
    parameter int REPLY_PERIOD_CYC = 10
) (
    // Clock
    input  wire logic ref_clk,
    // Status line level and pull-down enable
    input  wire logic line,
    output var  logic pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pull = 1'b0;
    task automatic request(input int width, input bit poke, output logic [7:0] n);
        int idle;
        int guard;
        bit poked;
        n = 8'h00;
        idle = 0;
        guard = 0;
        poked = 1'b0;
        @(posedge ref_clk);
        pull <= 1'b1;
        repeat (width) @(posedge ref_clk);
        pull <= 1'b0;
        @(posedge ref_clk);
        while (line !== 1'b0 && guard < 100) begin
            @(posedge ref_clk);
            guard++;
        end
        if (line !== 1'b0) return;
        n = 8'h01;
        // A reply ends once the line stays high beyond one period
        while (idle <= REPLY_PERIOD_CYC && guard < 2000) begin
            @(posedge ref_clk);
            guard++;
            if (pull) pull <= 1'b0;
            else if (line === 1'b0 && idle > 0) n++;
            idle = (line === 1'b1) ? idle + 1 : 0;
            if (poke && !poked && idle == 2) begin
                pull <= 1'b1;
                poked = 1'b1;
            end
        end
    endtask : request
endmodule : csr_host_model
`default_nettype wire

// ==== sim/csr_top_asserts.sv ====
// Purpose: Port-level checks of the charge status reporter
// Assumes: status_line_i carries the resolved pin level
// Notes:   Lamp checks allow up to three cycles of pipeline
`default_nettype none
module csr_top_asserts #(
    parameter int REPLY_START_DELAY_CYC = 20,
    parameter int REPLY_PULSE_LOW_CYC   = 5,
    parameter int REPLY_PERIOD_CYC      = 10
) (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Observed ports
    input wire csr_pkg::csr_charger_t charger_state,
    input wire logic                  status_line_i,
    input wire logic                  status_line_o,
    input wire logic                  status_line_oe,
    input wire logic                  lamp_out_primary_o,
    input wire logic                  lamp_out_primary_oe,
    input wire logic                  lamp_out_secondary_o,
    input wire logic                  lamp_out_secondary_oe
);
    localparam int DLY_LO = REPLY_START_DELAY_CYC + 2;
    localparam int DLY_HI = REPLY_START_DELAY_CYC + 5;
    logic [15:0] hi_cnt_r;
    logic [15:0] lo_cnt_r;
    logic        act;
    logic        flt;
    csr_pkg::csr_charger_t c;
    assign c = charger_state;
    assign act = c.charge_enabled & c.supply_ok & c.battery_present;
    assign flt = c.chip_over_temp | c.batt_temp_fault | c.over_voltage | c.cond_wdog | c.cc_wdog | c.cv_wdog;
    // ----------------------------------------
    // Pulse length counters
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hi_cnt_r <= 16'h0000;
            lo_cnt_r <= 16'h0000;
        end else begin
            hi_cnt_r <= status_line_oe ? hi_cnt_r + 16'h0001 : 16'h0000;
            // Saturates so a long idle never wraps into a false gap
            lo_cnt_r <= status_line_oe ? 16'h0000 : (lo_cnt_r == 16'hFFFF ? lo_cnt_r : lo_cnt_r + 16'h0001);
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_line_sink_only: assert property (status_line_o == 1'b0)
        else $error("status line driven high");
    a_lamp_sink_only: assert property (!lamp_out_primary_o && !lamp_out_secondary_o)
        else $error("lamp output driven high");
    a_lamps_off_idle: assert property ((!c.charge_enabled || !c.supply_ok) [*4] |-> !lamp_out_primary_oe && !lamp_out_secondary_oe)
        else $error("lamp lit while disabled");
    a_flash_in_step: assert property ((c.charge_enabled && c.supply_ok && !c.battery_present) [*4] |-> lamp_out_primary_oe == lamp_out_secondary_oe)
        else $error("flashing lamps out of step");
    a_fault_both_lit: assert property ((act && flt) [*4] |-> lamp_out_primary_oe && lamp_out_secondary_oe)
        else $error("fault lamp pattern wrong");
    a_done_second_lit: assert property ((act && !flt && c.charge_done) [*4] |-> !lamp_out_primary_oe && lamp_out_secondary_oe)
        else $error("done lamp pattern wrong");
    a_charge_first_lit: assert property ((act && !flt && !c.charge_done && c.cc_mode) [*4] |-> lamp_out_primary_oe && !lamp_out_secondary_oe)
        else $error("charging lamp pattern wrong");
    a_reply_delay_fixed: assert property ($rose(status_line_i) && !status_line_oe && lo_cnt_r > 2 * REPLY_PERIOD_CYC |-> ##[DLY_LO:DLY_HI] $rose(status_line_oe))
        else $error("reply start delay wrong");
    a_pulse_width_fixed: assert property ($fell(status_line_oe) |-> hi_cnt_r == REPLY_PULSE_LOW_CYC)
        else $error("reply pulse width wrong");
    a_pulse_gap_fixed: assert property ($rose(status_line_oe) && lo_cnt_r < REPLY_PERIOD_CYC |-> lo_cnt_r == REPLY_PERIOD_CYC - REPLY_PULSE_LOW_CYC)
        else $error("reply pulse period wrong");
    a_reset_all_off: assert property (disable iff (1'b0) rst |=> !status_line_oe && !lamp_out_primary_oe && !lamp_out_secondary_oe)
        else $error("output active after reset");
    c_reply_pulse: cover property ($rose(status_line_oe));
    c_fault_lamps: cover property (lamp_out_primary_oe && lamp_out_secondary_oe);
    c_done_lamp: cover property (!lamp_out_primary_oe && lamp_out_secondary_oe);
endmodule : csr_top_asserts
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the charge status reporter
// Assumes: Shortened counts: delay 20, pulse 5, period 10, strobe max 50
// Notes:   Status line modelled as pull-up with two sinking parties
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk;
    logic                  rst;
    csr_pkg::csr_charger_t charger_state;
    logic                  dev_o;
    logic                  dev_oe;
    logic                  host_pull;
    logic                  p_o;
    logic                  p_oe;
    logic                  s_o;
    logic                  s_oe;
    wire logic             status_line;
    int                    failures = 0;
    int                    compares = 0;
    int                    cycles = 0;
    assign status_line = ~(dev_oe | host_pull);
    csr_top #(.REPLY_START_DELAY_CYC(20), .REPLY_PULSE_LOW_CYC(5), .REPLY_PERIOD_CYC(10),
              .REQUEST_STROBE_MAX_CYC(50), .FLASH_HALF_CYC(8)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .charger_state(charger_state), .status_line_i(status_line),
        .status_line_o(dev_o), .status_line_oe(dev_oe), .lamp_out_primary_o(p_o),
        .lamp_out_primary_oe(p_oe), .lamp_out_secondary_o(s_o), .lamp_out_secondary_oe(s_oe));
    // Host model keeps its default period, which matches the shortened device period
    csr_host_model host_u (.ref_clk(ref_clk), .line(status_line), .pull(host_pull));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_lamps();
        logic [13:0] st [5];
        logic [1:0]  ex [5];
        st = '{14'h0003, 14'h0005, 14'h0807, 14'h000F, 14'h0047};
        ex = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h2};
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            charger_state <= st[i];
            repeat (5) @(posedge ref_clk);
            chk("lamp enables", {6'h00, p_oe, s_oe}, {6'h00, ex[i]});
            chk("lamp drive levels", {6'h00, p_o, s_o}, 8'h00);
        end
        $display("t_lamps done");
    endtask : t_lamps
    task automatic t_flash();
        int         tog;
        logic       prev;
        logic [7:0] mism;
        tog = 0;
        mism = 8'h00;
        @(posedge ref_clk);
        charger_state <= 14'h0006;
        repeat (5) @(posedge ref_clk);
        prev = p_oe;
        for (int k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            if (p_oe !== s_oe) mism++;
            if (p_oe !== prev) tog++;
            prev = p_oe;
        end
        chk("flash pair mismatches", mism, 8'h00);
        chk("flash toggles seen", {7'h00, tog >= 4}, 8'h01);
        $display("t_flash done");
    endtask : t_flash
    task automatic t_reports();
        logic [4:0] tab [11];
        logic [7:0] n;
        tab = '{csr_pkg::CNT_CHIP_OT, csr_pkg::CNT_BATT_TEMP, csr_pkg::CNT_OVER_VOLT, csr_pkg::CNT_COND_WDOG,
                csr_pkg::CNT_COND, csr_pkg::CNT_CC_WDOG, csr_pkg::CNT_CC_TLOOP, csr_pkg::CNT_CC,
                csr_pkg::CNT_CV_WDOG, csr_pkg::CNT_CV, csr_pkg::CNT_DONE};
        for (int i = 0; i < 11; i++) begin
            charger_state <= 14'h0007 | (14'h2000 >> i);
            host_u.request(20, 1'b0, n);
            chk("pulse count", n, {3'h0, tab[i]});
        end
        charger_state <= 14'h0007;
        host_u.request(20, 1'b0, n);
        chk("pulse count without state", n, {3'h0, csr_pkg::CNT_ERROR});
        $display("t_reports done");
    endtask : t_reports
    task automatic t_strobes();
        logic [7:0] n;
        charger_state <= 14'h0047;
        host_u.request(60, 1'b0, n);
        chk("pulse count after long strobe", n, {3'h0, csr_pkg::CNT_ERROR});
        host_u.request(20, 1'b1, n);
        chk("pulse count with edge in reply", n, {3'h0, csr_pkg::CNT_CC});
        host_u.request(20, 1'b0, n);
        chk("pulse count back to back", n, {3'h0, csr_pkg::CNT_CC});
        $display("t_strobes done");
    endtask : t_strobes
    initial begin
        rst = 1'b1;
        charger_state = 14'h0047;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("line released after reset", {7'h00, dev_oe}, 8'h00);
        t_lamps();
        t_flash();
        t_reports();
        t_strobes();
        wrap_up();
    end
endmodule : tb_top
bind csr_top csr_top_asserts #(.REPLY_START_DELAY_CYC(REPLY_START_DELAY_CYC),
    .REPLY_PULSE_LOW_CYC(REPLY_PULSE_LOW_CYC), .REPLY_PERIOD_CYC(REPLY_PERIOD_CYC)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .charger_state(charger_state), .status_line_i(status_line_i),
    .status_line_o(status_line_o), .status_line_oe(status_line_oe), .lamp_out_primary_o(lamp_out_primary_o),
    .lamp_out_primary_oe(lamp_out_primary_oe), .lamp_out_secondary_o(lamp_out_secondary_o),
    .lamp_out_secondary_oe(lamp_out_secondary_oe));
`default_nettype wire

// ==== src/csr_lamp.sv ====
// Purpose: Status lamp decode with flashing for absent battery
// Assumes: Charger condition stable on ref_clk
// Notes:   Outputs are lamp-on levels; top turns them into pin enables
`default_nettype none
module csr_lamp #(
    parameter int FLASH_HALF_CYC = csr_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Condition
    input  wire csr_pkg::csr_charger_t chg,
    // Lamps
    output var  csr_pkg::csr_lamp_t lamp
);
    logic [31:0] flash_cnt_r;
    logic        flash_r;
    logic        fault;

    assign fault = chg.chip_over_temp | chg.batt_temp_fault | chg.over_voltage
                 | chg.cond_wdog | chg.cc_wdog | chg.cv_wdog;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= 1'b0;
        end else if (flash_cnt_r == 32'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= ~flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lamp <= '0;
        end else if (!chg.charge_enabled || !chg.supply_ok) begin
            lamp <= '0;                                        // see RULE10
        end else if (!chg.battery_present) begin
            lamp <= '{primary_on: flash_r, secondary_on: flash_r}; // see RULE11
        end else if (fault) begin
            lamp <= '{primary_on: 1'b1, secondary_on: 1'b1};   // see RULE12
        end else if (chg.charge_done) begin
            lamp <= '{primary_on: 1'b0, secondary_on: 1'b1};   // see RULE12, see RULE13
        end else begin
            lamp <= '{primary_on: 1'b1, secondary_on: 1'b0};   // see RULE12, see RULE13
        end
    end
endmodule : csr_lamp
`default_nettype wire

// ==== src/csr_pkg.sv ====
// Purpose: Shared types and constants for the charge status reporter
// Assumes: 100 MHz ref_clk
// Notes:   Timing figures in ns, cycle counts derived from them
`default_nettype none
package csr_pkg;
    localparam int CLK_PERIOD_NS            = 10;
    localparam int REQUEST_STROBE_MIN_NS    = 200;
    localparam int REQUEST_STROBE_MIN_CYC   = (REQUEST_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REQUEST_STROBE_MAX_NS    = 100000;
    localparam int REQUEST_STROBE_MAX_CYC   = REQUEST_STROBE_MAX_NS / CLK_PERIOD_NS;
    localparam int REPLY_START_DELAY_NS     = 20000;
    localparam int REPLY_START_DELAY_CYC    = REPLY_START_DELAY_NS / CLK_PERIOD_NS;
    localparam int REPLY_PULSE_LOW_NS       = 5000;
    localparam int REPLY_PULSE_LOW_CYC      = REPLY_PULSE_LOW_NS / CLK_PERIOD_NS;
    localparam int REPLY_PERIOD_NS          = 10000;
    localparam int REPLY_PERIOD_CYC         = REPLY_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FLASH_HALF_NS            = 250000000;
    localparam int FLASH_HALF_CYC           = FLASH_HALF_NS / CLK_PERIOD_NS;

    localparam logic [4:0] CNT_CHIP_OT      = 5'h01;
    localparam logic [4:0] CNT_BATT_TEMP    = 5'h02;
    localparam logic [4:0] CNT_OVER_VOLT    = 5'h03;
    localparam logic [4:0] CNT_COND_WDOG    = 5'h05;
    localparam logic [4:0] CNT_COND         = 5'h06;
    localparam logic [4:0] CNT_CC_WDOG      = 5'h07;
    localparam logic [4:0] CNT_CC_TLOOP     = 5'h08;
    localparam logic [4:0] CNT_CC           = 5'h09;
    localparam logic [4:0] CNT_CV_WDOG      = 5'h0A;
    localparam logic [4:0] CNT_CV           = 5'h0B;
    localparam logic [4:0] CNT_DONE         = 5'h0C;
    localparam logic [4:0] CNT_ERROR        = 5'h17;

    // Charger condition, one-hot priority order high bit first
    typedef struct packed {
        logic chip_over_temp;
        logic batt_temp_fault;
        logic over_voltage;
        logic cond_wdog;
        logic cond_mode;
        logic cc_wdog;
        logic cc_tloop;
        logic cc_mode;
        logic cv_wdog;
        logic cv_mode;
        logic charge_done;
        logic charge_enabled;
        logic supply_ok;
        logic battery_present;
    } csr_charger_t;

    typedef struct packed {
        logic primary_on;
        logic secondary_on;
    } csr_lamp_t;
endpackage : csr_pkg
`default_nettype wire

// ==== src/csr_sync.sv ====
// Purpose: Two-flop synchroniser for the shared status line
// Assumes: Input asynchronous to ref_clk
// Notes:   First stage read only by the second
`default_nettype none
module csr_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Data
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : csr_sync
`default_nettype wire

// ==== src/csr_top.sv ====
// Purpose: Charge status reporter: lamp drivers and single-wire pulse reply
// Assumes: Status line has external pull-up; host strobes low then releases
// Notes:   Lamps and status line are open drain: only enables ever drive low
`default_nettype none
// Operation
// RULE1: Host requests by low strobe, at least 200 ns
// RULE2: Host keeps strobe below maximum duration
// RULE3: After strobe rising edge, delay, then pulses
// RULE4: Status line active low, only pulled low
// RULE5: Counts 1-3 faults, 4 unused, 23 error
// RULE6: 5 conditioning timeout, 6 conditioning mode
// RULE7: 7 CC timeout, 8 thermal loop, 9 CC
// RULE8: 10 CV timeout, 11 CV, 12 done
// RULE9: Lamp outputs only sink, never drive high
// RULE10: Disabled or low supply: both lamps off
// RULE11: No battery: both lamps flash together
// RULE12: Charging, complete, fault lamp patterns
// RULE13: Primary lamp alone shows charging state
// RULE14: Delay, width, period are parameters; host counts
// RULE15: Ignore line edges while reply in progress
module csr_top #(
    parameter int REPLY_START_DELAY_CYC  = csr_pkg::REPLY_START_DELAY_CYC,
    parameter int REPLY_PULSE_LOW_CYC    = csr_pkg::REPLY_PULSE_LOW_CYC,
    parameter int REPLY_PERIOD_CYC       = csr_pkg::REPLY_PERIOD_CYC,
    parameter int REQUEST_STROBE_MAX_CYC = csr_pkg::REQUEST_STROBE_MAX_CYC,
    parameter int FLASH_HALF_CYC         = csr_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Charger condition from charge control
    input  wire csr_pkg::csr_charger_t charger_state,
    // Status line, open drain
    input  wire logic                  status_line_i,
    output var  logic                  status_line_o,
    output var  logic                  status_line_oe,
    // Lamps, open drain
    output var  logic                  lamp_out_primary_o,
    output var  logic                  lamp_out_primary_oe,
    output var  logic                  lamp_out_secondary_o,
    output var  logic                  lamp_out_secondary_oe
);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSR_IDLE  = 2'b00,
        CSR_STROBE = 2'b01,
        CSR_DELAY = 2'b11,
        CSR_SEND  = 2'b10
    } csr_state_t;

    csr_state_t         state_r;
    logic               line_s;
    logic               line_d_r;
    logic [31:0]        tmr_r;
    logic [4:0]         pulses_left_r;
    logic [4:0]         report_cnt;
    logic               strobe_bad_r;
    csr_pkg::csr_lamp_t lamp;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    csr_sync u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (status_line_i),
        .sync_out (line_s)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            line_d_r <= 1'b1;
        end else begin
            line_d_r <= line_s;
        end
    end

    // ------------------------------------------------------------
    // Report encoding, highest priority first
    // ------------------------------------------------------------
    function automatic logic [4:0] csr_encode(input csr_pkg::csr_charger_t c);
        logic [4:0] n;
        n = csr_pkg::CNT_ERROR;                             // see RULE5
        if (c.chip_over_temp)       n = csr_pkg::CNT_CHIP_OT;   // see RULE5
        else if (c.batt_temp_fault) n = csr_pkg::CNT_BATT_TEMP; // see RULE5
        else if (c.over_voltage)    n = csr_pkg::CNT_OVER_VOLT; // see RULE5
        else if (c.cond_wdog)       n = csr_pkg::CNT_COND_WDOG; // see RULE6
        else if (c.cond_mode)       n = csr_pkg::CNT_COND;      // see RULE6
        else if (c.cc_wdog)         n = csr_pkg::CNT_CC_WDOG;   // see RULE7
        else if (c.cc_tloop)        n = csr_pkg::CNT_CC_TLOOP;  // see RULE7
        else if (c.cc_mode)         n = csr_pkg::CNT_CC;        // see RULE7
        else if (c.cv_wdog)         n = csr_pkg::CNT_CV_WDOG;   // see RULE8
        else if (c.cv_mode)         n = csr_pkg::CNT_CV;        // see RULE8
        else if (c.charge_done)     n = csr_pkg::CNT_DONE;      // see RULE8
        return n;
    endfunction : csr_encode

    assign report_cnt = csr_encode(charger_state);

    // ------------------------------------------------------------
    // Reply sequencer
    // ------------------------------------------------------------
    // Over-long strobe is answered with the error count rather than dropped,
    // so the host always sees a reply it can recognise.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r       <= CSR_IDLE;
            tmr_r         <= 32'h0000_0000;
            pulses_left_r <= 5'h00;
            strobe_bad_r  <= 1'b0;
        end else begin
            unique case (state_r)
                CSR_IDLE: begin
                    if (line_d_r && !line_s) begin
                        state_r      <= CSR_STROBE;
                        tmr_r        <= 32'h0000_0000;
                        strobe_bad_r <= 1'b0;
                    end
                end
                CSR_STROBE: begin
                    if (line_s) begin
                        state_r <= CSR_DELAY;                       // see RULE3
                        tmr_r   <= 32'h0000_0000;
                    end else if (tmr_r == 32'(REQUEST_STROBE_MAX_CYC)) begin
                        strobe_bad_r <= 1'b1;                       // see RULE2
                    end else begin
                        tmr_r <= tmr_r + 32'h0000_0001;
                    end
                end
                CSR_DELAY: begin
                    if (tmr_r == 32'(REPLY_START_DELAY_CYC - 1)) begin
                        state_r       <= CSR_SEND;                  // see RULE3, see RULE14
                        tmr_r         <= 32'h0000_0000;
                        pulses_left_r <= strobe_bad_r ? csr_pkg::CNT_ERROR : report_cnt;
                    end else begin
                        tmr_r <= tmr_r + 32'h0000_0001;
                    end
                end
                CSR_SEND: begin
                    // Line activity ignored here: own pulses are not requests
                    if (tmr_r == 32'(REPLY_PERIOD_CYC - 1)) begin   // see RULE15, see RULE14
                        tmr_r         <= 32'h0000_0000;
                        pulses_left_r <= pulses_left_r - 5'h01;
                        if (pulses_left_r == 5'h01) begin
                            state_r <= CSR_IDLE;
                        end
                    end else begin
                        tmr_r <= tmr_r + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_line_o  <= 1'b0;
            status_line_oe <= 1'b0;
        end else begin
            status_line_o  <= 1'b0;                                 // see RULE4
            status_line_oe <= (state_r == CSR_SEND) && (tmr_r < 32'(REPLY_PULSE_LOW_CYC))
                              && (pulses_left_r != 5'h00);          // see RULE4, see RULE3
        end
    end

    csr_lamp #(
        .FLASH_HALF_CYC (FLASH_HALF_CYC)
    ) u_lamp (
        .ref_clk (ref_clk),
        .rst     (rst),
        .chg     (charger_state),
        .lamp    (lamp)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lamp_out_primary_o    <= 1'b0;
            lamp_out_primary_oe   <= 1'b0;
            lamp_out_secondary_o  <= 1'b0;
            lamp_out_secondary_oe <= 1'b0;
        end else begin
            lamp_out_primary_o    <= 1'b0;                          // see RULE9
            lamp_out_primary_oe   <= lamp.primary_on;               // see RULE9, see RULE13
            lamp_out_secondary_o  <= 1'b0;                          // see RULE9
            lamp_out_secondary_oe <= lamp.secondary_on;             // see RULE9
        end
    end
endmodule : csr_top
`default_nettype wire
